// ===== logic/log_page_pkg.sv
// Constants and types for the drive log sector builder
// Operation
// RQ1: Directory word at offset zero holds version 0001h.
// RQ2: Version 0000h would mean no directory; host reads it so.
// RQ3: Directory holds a 16-bit sector count per log address at 2N, 2N+1.
// RQ4: Host vendor logs 80h to 9Fh are reported as 16 sectors.
// RQ5: Byte 020h shows queuing support, byte 021h is zero.
// RQ6: Byte 022h shows phy counter support, byte 023h is zero.
// RQ7: Byte 024h shows queue management support, byte 025h is zero.
// RQ8: Byte 02Ah shows rebuild assist support, 02Bh zero, others reserved.
// RQ9: Errors from faulty host commands are never logged.
// RQ10: Error sector: version, index, four 124-byte entries, count, checksum.
// RQ11: Error log version byte is always 01h.
// RQ12: Error index names newest entry, zero when empty, range 0 to 4.
// RQ13: Four error entries form a ring; unwritten entries read zero.
// RQ14: Entry is five 18-byte command records then a 34-byte error record.
// RQ15: Command record holds control, register pairs, command and millisecond stamp.
// RQ16: Command pair low byte is latest write, high byte the replaced value.
// RQ17: Error record holds error, pairs, status, state and hour count.
// RQ18: Error pair low byte reads with control bit 7 clear, high with it set.
// RQ19: State low nibble: unknown, sleep, standby, active, self-test; rest reserved or vendor.
// RQ20: Device error count sums device-caused errors over life.
// RQ21: Device error count saturates at its maximum.
// RQ22: Self-test sector: revision 01h, index, eighteen 26-byte descriptors, checksum.
// RQ23: Eighteen descriptors form a ring; unused ones read zero.
// RQ24: Self-test index names newest descriptor, zero when none, range 0 to 18.
// RQ25: Checksum byte makes the sum of all 512 bytes zero modulo 256.
package log_page_pkg;
    localparam logic [7:0] LOG_DIR = 8'h00;
    localparam logic [7:0] LOG_ERR = 8'h03;
    localparam logic [7:0] LOG_ST = 8'h07;
    localparam logic [8:0] SECTOR_LAST = 9'h1_FF;
    localparam logic [15:0] DIR_VERSION = 16'h0001;
    localparam logic [7:0] VENDOR_FIRST = 8'h80;
    localparam logic [7:0] VENDOR_LAST = 8'h9F;
    localparam logic [7:0] VENDOR_SECTORS = 8'h10;
    localparam logic [7:0] ERR_SECTORS = 8'h01;
    localparam logic [7:0] ST_SECTORS = 8'h01;
    localparam logic [8:0] DIR_NCQ = 9'h0_20;
    localparam logic [8:0] DIR_PHY = 9'h0_22;
    localparam logic [8:0] DIR_QM = 9'h0_24;
    localparam logic [8:0] DIR_REBUILD = 9'h0_2A;
    localparam logic [7:0] ERR_VERSION = 8'h01;
    localparam logic [7:0] ST_REVISION = 8'h01;
    localparam logic [8:0] OFF_INDEX = 9'h0_02;
    localparam logic [8:0] OFF_FIRST = 9'h0_04;
    localparam logic [8:0] OFF_ERR_COUNT = 9'h1_F4;
    localparam int ERR_ENTRY_BYTES = 124;
    localparam int ST_DESC_BYTES = 26;
    localparam logic [2:0] ERR_ENTRIES = 3'h4;
    localparam logic [4:0] ST_ENTRIES = 5'h12;
    localparam logic [3:0] STATE_UNKNOWN = 4'h0;
    localparam logic [3:0] STATE_SELFTEST = 4'h4;
    localparam logic [3:0] STATE_VENDOR_FIRST = 4'hB;
    localparam logic [3:0] STATE_UPPER = 4'h0;
    // Register pairs: [7:0] latest or HOB=0 view, [15:8] replaced or HOB=1 view
    typedef struct packed {
        logic [31:0] stamp_ms;
        logic [7:0] command;
        logic [7:0] dev_head;
        logic [15:0] cyl_hi;
        logic [15:0] cyl_lo;
        logic [15:0] sec_num;
        logic [15:0] sec_cnt;
        logic [15:0] features;
        logic [7:0] dev_ctl;
    } cmd_rec_t;
    typedef struct packed {
        logic [15:0] hours;
        logic [3:0] state;
        logic [7:0] status;
        logic [7:0] dev_head;
        logic [15:0] cyl_hi;
        logic [15:0] cyl_lo;
        logic [15:0] sec_num;
        logic [15:0] sec_cnt;
        logic [7:0] error;
    } err_rec_t;
    typedef struct packed {
        err_rec_t err;
        cmd_rec_t [4:0] cmds;
    } err_entry_t;
    typedef struct packed {
        logic [47:0] fail_lba;
        logic [7:0] check_point;
        logic [15:0] hours;
        logic [7:0] status;
        logic [7:0] number;
    } st_desc_t;
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } out_word_t;
    typedef enum logic {S_IDLE, S_RUN} stream_state_t;
endpackage : log_page_pkg

// ===== logic/drive_log_page_builder.sv
// Log sector builder: error and self-test rings, directory, byte stream out
`timescale 1ns/10ps
module drive_log_page_builder
    import log_page_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Feature support straps
    input wire logic ncq_supported,
    input wire logic phy_counters_supported,
    input wire logic queue_mgmt_supported,
    input wire logic rebuild_assist_supported,
    // Error event
    input wire logic err_valid,
    input wire logic err_faulty_cmd,
    input wire err_entry_t err_entry,
    // Self-test completion event
    input wire logic st_valid,
    input wire st_desc_t st_desc,
    // Read request
    input wire logic rd_start,
    input wire logic [7:0] rd_log,
    output logic rd_busy,
    // Sector byte stream
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_last,
    input wire logic out_ready
);
    typedef struct packed {
        stream_state_t fsm;
        logic [7:0] sel;
        logic [8:0] offset;
        logic [7:0] sum;
        out_word_t head;
        out_word_t spare;
        logic [2:0] err_index;
        logic [15:0] err_count;
        err_entry_t [3:0] err_mem;
        logic [4:0] st_index;
        st_desc_t [17:0] st_mem;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic push;
    logic [7:0] push_byte;
    logic err_take;

    function automatic logic [143:0] cmd_vec(input cmd_rec_t c);
        cmd_vec = {c.stamp_ms, 8'h00, c.command, c.dev_head, c.cyl_hi, c.cyl_lo,
                   c.sec_num, c.sec_cnt, c.features, c.dev_ctl}; // see RQ15 see RQ16
    endfunction : cmd_vec

    function automatic logic [271:0] err_vec(input err_rec_t e);
        err_vec = {e.hours, STATE_UPPER, e.state, 152'h0, e.status, e.dev_head,
                   e.cyl_hi, e.cyl_lo, e.sec_num, e.sec_cnt, e.error, 8'h00}; // see RQ17 see RQ18
    endfunction : err_vec

    function automatic logic [991:0] entry_vec(input err_entry_t en);
        entry_vec = {err_vec(en.err), cmd_vec(en.cmds[4]), cmd_vec(en.cmds[3]),
                     cmd_vec(en.cmds[2]), cmd_vec(en.cmds[1]), cmd_vec(en.cmds[0])}; // see RQ14
    endfunction : entry_vec

    function automatic logic [207:0] desc_vec(input st_desc_t d);
        desc_vec = {120'h0, d.fail_lba, d.check_point, d.hours, d.status, d.number};
    endfunction : desc_vec

    // Reserved state codes are stored as unknown
    function automatic logic [3:0] clean_state(input logic [3:0] s);
        if (s > STATE_SELFTEST && s < STATE_VENDOR_FIRST) begin
            clean_state = STATE_UNKNOWN; // see RQ19
        end else begin
            clean_state = s;
        end
    endfunction : clean_state

    function automatic logic [7:0] dir_byte(input logic [8:0] off, input logic [3:0] flags);
        logic [7:0] addr;
        addr = off[8:1];
        dir_byte = 8'h00;
        if (off == 9'h0_00) begin
            dir_byte = DIR_VERSION[7:0]; // see RQ1 see RQ2
        end else if (off == 9'h0_01) begin
            dir_byte = DIR_VERSION[15:8]; // see RQ1
        end else if (!off[0]) begin // see RQ3
            if (addr >= VENDOR_FIRST && addr <= VENDOR_LAST) begin
                dir_byte = VENDOR_SECTORS; // see RQ4
            end else if (addr == LOG_ERR) begin
                dir_byte = ERR_SECTORS;
            end else if (addr == LOG_ST) begin
                dir_byte = ST_SECTORS;
            end else if (off == DIR_NCQ) begin
                dir_byte = {7'h00, flags[0]}; // see RQ5
            end else if (off == DIR_PHY) begin
                dir_byte = {7'h00, flags[1]}; // see RQ6
            end else if (off == DIR_QM) begin
                dir_byte = {7'h00, flags[2]}; // see RQ7
            end else if (off == DIR_REBUILD) begin
                dir_byte = {7'h00, flags[3]}; // see RQ8
            end
        end
    endfunction : dir_byte

    function automatic logic [7:0] err_byte(input logic [8:0] off, input state_t s);
        int rel;
        int ei;
        int w;
        logic [991:0] v;
        rel = int'(off) - int'(OFF_FIRST);
        ei = rel / ERR_ENTRY_BYTES;
        w = rel % ERR_ENTRY_BYTES;
        err_byte = 8'h00;
        v = '0;
        if (off == 9'h0_00) begin
            err_byte = ERR_VERSION; // see RQ11
        end else if (off == OFF_INDEX) begin
            err_byte = {5'h00, s.err_index};
        end else if (off == OFF_ERR_COUNT) begin
            err_byte = s.err_count[7:0];
        end else if (off == OFF_ERR_COUNT + 9'h0_01) begin
            err_byte = s.err_count[15:8];
        end else if (rel >= 0 && ei < 4) begin // see RQ10
            v = entry_vec(s.err_mem[ei]);
            err_byte = v[w*8 +: 8];
        end
    endfunction : err_byte

    function automatic logic [7:0] st_byte(input logic [8:0] off, input state_t s);
        int rel;
        int di;
        int w;
        logic [207:0] v;
        rel = int'(off) - int'(OFF_FIRST);
        di = rel / ST_DESC_BYTES;
        w = rel % ST_DESC_BYTES;
        st_byte = 8'h00;
        v = '0;
        if (off == 9'h0_00) begin
            st_byte = ST_REVISION; // see RQ22
        end else if (off == OFF_INDEX) begin
            st_byte = {3'h0, s.st_index};
        end else if (rel >= 0 && di < 18) begin // see RQ22
            v = desc_vec(s.st_mem[di]);
            st_byte = v[w*8 +: 8];
        end
    endfunction : st_byte

    always_comb begin
        logic [7:0] raw;
        logic [2:0] eslot;
        logic [4:0] sslot;
        logic pop;
        raw = 8'h00;
        eslot = 3'h0;
        sslot = 5'h0;
        pop = 1'b0;
        state_next = state_reg;
        err_take = err_valid && !err_faulty_cmd; // see RQ9 see RQ20
        push = (state_reg.fsm == S_RUN) && !state_reg.spare.valid;
        unique case (state_reg.sel)
            LOG_ERR: raw = err_byte(state_reg.offset, state_reg);
            LOG_ST: raw = st_byte(state_reg.offset, state_reg);
            default: raw = dir_byte(state_reg.offset, {rebuild_assist_supported,
                queue_mgmt_supported, phy_counters_supported, ncq_supported});
        endcase
        if (state_reg.sel != LOG_DIR && state_reg.offset == SECTOR_LAST) begin
            push_byte = 8'h00 - state_reg.sum; // see RQ25
        end else begin
            push_byte = raw;
        end

        // Stream control
        unique case (state_reg.fsm)
            S_IDLE: begin
                if (rd_start && (rd_log == LOG_DIR || rd_log == LOG_ERR || rd_log == LOG_ST)) begin
                    state_next.fsm = S_RUN;
                    state_next.sel = rd_log;
                    state_next.offset = 9'h0_00;
                    state_next.sum = 8'h00;
                end
            end
            S_RUN: begin
                if (push) begin
                    state_next.sum = state_reg.sum + push_byte;
                    state_next.offset = state_reg.offset + 9'h0_01;
                    if (state_reg.offset == SECTOR_LAST) begin
                        state_next.fsm = S_IDLE;
                    end
                end
            end
        endcase

        // Two-entry output buffer
        pop = state_reg.head.valid && out_ready;
        if (pop) begin
            state_next.head = state_reg.spare;
            state_next.spare = '0;
        end
        if (push) begin
            if (!state_next.head.valid) begin
                state_next.head = '{valid: 1'b1, last: state_reg.offset == SECTOR_LAST, data: push_byte};
            end else begin
                state_next.spare = '{valid: 1'b1, last: state_reg.offset == SECTOR_LAST, data: push_byte};
            end
        end

        // Error ring
        if (err_take) begin
            eslot = (state_reg.err_index == ERR_ENTRIES) ? 3'h1 : state_reg.err_index + 3'h1; // see RQ12 see RQ13
            state_next.err_index = eslot;
            state_next.err_mem[eslot - 3'h1] = err_entry;
            state_next.err_mem[eslot - 3'h1].err.state = clean_state(err_entry.err.state);
            if (state_reg.err_count != 16'hFF_FF) begin
                state_next.err_count = state_reg.err_count + 16'h0_001; // see RQ21
            end
        end

        // Self-test ring
        if (st_valid) begin
            sslot = (state_reg.st_index == ST_ENTRIES) ? 5'h01 : state_reg.st_index + 5'h01; // see RQ23 see RQ24
            state_next.st_index = sslot;
            state_next.st_mem[sslot - 5'h01] = st_desc;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign out_valid = state_reg.head.valid;
    assign out_data = state_reg.head.data;
    assign out_last = state_reg.head.last;
    assign rd_busy = state_reg.fsm == S_RUN;

    // Checks
    a_dir_version: assert property (@(posedge clk) disable iff (!rst_n)
        push && state_reg.sel == LOG_DIR && state_reg.offset == 9'h0_00 |-> push_byte == 8'h01)
        else $error("directory version low byte wrong"); // see RQ1
    a_vendor_sixteen: assert property (@(posedge clk) disable iff (!rst_n)
        push && state_reg.sel == LOG_DIR && state_reg.offset[8:7] == 2'b10 && state_reg.offset[6]
        == 1'b0 && !state_reg.offset[0] |-> push_byte == 8'h10)
        else $error("vendor log count not 16"); // see RQ4
    a_err_version: assert property (@(posedge clk) disable iff (!rst_n)
        push && state_reg.sel == LOG_ERR && state_reg.offset == 9'h0_00 |-> push_byte == 8'h01)
        else $error("error log version wrong"); // see RQ11
    a_err_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        err_take && state_reg.err_index == 3'h4 |=> state_reg.err_index == 3'h1)
        else $error("error ring did not wrap"); // see RQ13
    a_faulty_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        err_valid && err_faulty_cmd |=> $stable(state_reg.err_index) && $stable(state_reg.err_count))
        else $error("faulty command was logged"); // see RQ9
    a_count_saturates: assert property (@(posedge clk) disable iff (!rst_n)
        err_take && state_reg.err_count == 16'hFF_FF |=> state_reg.err_count == 16'hFF_FF)
        else $error("error count wrapped"); // see RQ21
    a_err_index_range: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg.err_index <= 3'h4)
        else $error("error index out of range"); // see RQ12
    a_st_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        st_valid && state_reg.st_index == 5'h12 |=> state_reg.st_index == 5'h01 && state_reg.st_index <= 5'h12)
        else $error("self-test ring did not wrap"); // see RQ23 see RQ24
    a_sector_length: assert property (@(posedge clk) disable iff (!rst_n)
        push && state_reg.offset == 9'h1_FF |=> state_reg.fsm == S_IDLE && !push)
        else $error("sector did not end after 512 bytes"); // see RQ10 see RQ22
    a_checksum_zero: assert property (@(posedge clk) disable iff (!rst_n)
        push && state_reg.sel != LOG_DIR && state_reg.offset == 9'h1_FF |-> 8'(state_reg.sum + push_byte) == 8'h00)
        else $error("sector checksum not zero"); // see RQ25
    c_err_read: cover property (@(posedge clk) disable iff (!rst_n)
        out_valid && out_last && out_ready && state_reg.sel == LOG_ERR);
    c_err_wrap: cover property (@(posedge clk) disable iff (!rst_n)
        err_take && state_reg.err_index == 3'h4);
    c_stall: cover property (@(posedge clk) disable iff (!rst_n)
        state_reg.spare.valid && !out_ready);
    c_st_wrap: cover property (@(posedge clk) disable iff (!rst_n)
        st_valid && state_reg.st_index == 5'h12);
endmodule : drive_log_page_builder

// ===== test/log_sink.sv
// Host-side sink that captures one log sector, optionally stalling
`timescale 1ns/10ps
module log_sink (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench control
    input wire logic clr,
    input wire logic stall,
    // Sector byte stream
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    output logic out_ready,
    // Capture state
    output logic [9:0] n_got,
    output logic [9:0] last_pos,
    output logic dir_present
);
    logic [7:0] mem [0:511];
    logic [1:0] cyc;
    // A zero version word means the directory is absent
    assign dir_present = (mem[0] !== 8'h00) || (mem[1] !== 8'h00);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            n_got <= 10'h000;
            last_pos <= 10'h000;
            cyc <= 2'h0;
            out_ready <= 1'b0;
        end else begin
            cyc <= cyc + 2'h1;
            out_ready <= !stall || (cyc == 2'h0);
            if (clr) begin
                n_got <= 10'h000;
                last_pos <= 10'h3FF;
            end else if (out_valid && out_ready) begin
                mem[n_got[8:0]] <= out_data;
                n_got <= n_got + 10'h001;
                if (out_last) last_pos <= n_got;
            end
        end
    end
endmodule : log_sink

// ===== test/tb.sv
// Self-checking bench for the log sector builder
`timescale 1ns/10ps
module tb;
    import log_page_pkg::*;
    logic clk, rst_n, ncq, phy, qm, reb, err_valid, err_faulty_cmd, st_valid, rd_start, rd_busy;
    logic out_valid, out_last, out_ready, clr, stall, dir_present;
    logic [7:0] rd_log, out_data;
    logic [9:0] n_got, last_pos;
    err_entry_t err_entry;
    st_desc_t st_desc;
    int n_fail = 0;
    int n_tests = 0;

    drive_log_page_builder DUT (.clk(clk), .rst_n(rst_n), .ncq_supported(ncq), .phy_counters_supported(phy),
        .queue_mgmt_supported(qm), .rebuild_assist_supported(reb), .err_valid(err_valid),
        .err_faulty_cmd(err_faulty_cmd), .err_entry(err_entry), .st_valid(st_valid), .st_desc(st_desc),
        .rd_start(rd_start), .rd_log(rd_log), .rd_busy(rd_busy), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .out_ready(out_ready));
    log_sink sink (.clk(clk), .rst_n(rst_n), .clr(clr), .stall(stall), .out_valid(out_valid),
        .out_data(out_data), .out_last(out_last), .out_ready(out_ready), .n_got(n_got),
        .last_pos(last_pos), .dir_present(dir_present));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic chk_b(input int off, input logic [7:0] exp, input string msg);
        chk({8'h00, sink.mem[off]}, {8'h00, exp}, msg);
    endtask : chk_b

    task automatic chk_zero(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) chk_b(i, 8'h00, "unused byte");
    endtask : chk_zero

    task automatic chk_sum();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 512; i++) s = s + sink.mem[i];
        chk({8'h00, s}, 16'h0000, "sector sum");
    endtask : chk_sum

    // Second start while busy must be ignored
    task automatic read_log(input logic [7:0] a, input logic poke);
        int i;
        @(posedge clk);
        clr <= 1'b1;
        rd_log <= a;
        rd_start <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        rd_start <= 1'b0;
        if (poke) begin
            @(posedge clk);
            rd_log <= LOG_ERR;
            rd_start <= 1'b1;
            @(posedge clk);
            rd_start <= 1'b0;
        end
        // Let the clear of the previous count land before polling it
        @(posedge clk);
        for (i = 0; i < 5000 && n_got !== 10'h200; i++) @(posedge clk);
        #1;
        if (n_got !== 10'h200) begin
            n_fail++;
            $display("[FAIL] %0t read did not complete", $time);
            summarize();
        end
        chk({6'h00, last_pos}, 16'h01FF, "last marker");
        chk({15'h0000, rd_busy}, 16'h0000, "busy after read");
    endtask : read_log

    function automatic err_entry_t mk_err(input logic [7:0] n);
        err_entry_t e;
        e = '0;
        for (int i = 0; i < 5; i++) begin
            e.cmds[i].dev_ctl = n + 8'(i);
            e.cmds[i].features = {8'hF0, n};
            e.cmds[i].command = 8'h25;
            e.cmds[i].stamp_ms = {24'h12_3456, n};
        end
        e.err.error = 8'h40;
        e.err.sec_cnt = {8'h0C, n};
        e.err.status = 8'h51;
        e.err.state = n[3:0];
        e.err.hours = {8'h77, n};
        return e;
    endfunction : mk_err

    task automatic chk_entry(input int b, input logic [7:0] n);
        logic [7:0] st;
        st = (n[3:0] >= 4'h5 && n[3:0] <= 4'hA) ? 8'h00 : {4'h0, n[3:0]};
        for (int i = 0; i < 5; i++) begin
            chk_b(b + 18 * i, n + 8'(i), "control");
            chk_b(b + 18 * i + 1, n, "features latest");
            chk_b(b + 18 * i + 2, 8'hF0, "features prior");
            chk_b(b + 18 * i + 12, 8'h25, "command");
            chk_b(b + 18 * i + 17, 8'h12, "stamp top");
        end
        chk_b(b + 91, 8'h40, "error");
        chk_b(b + 92, n, "count clear view");
        chk_b(b + 93, 8'h0C, "count set view");
        chk_b(b + 101, 8'h51, "status");
        chk_b(b + 121, st, "state");
        chk_b(b + 123, 8'h77, "hours high");
    endtask : chk_entry

    task automatic errs(input logic [7:0] n, input int cnt, input int step, input logic faulty);
        for (int i = 0; i < cnt; i++) begin
            @(posedge clk);
            err_valid <= 1'b1;
            err_faulty_cmd <= faulty;
            err_entry <= mk_err(n + 8'(i * step));
            stall <= 1'b0;
        end
        @(posedge clk);
        err_valid <= 1'b0;
        err_faulty_cmd <= 1'b0;
    endtask : errs

    task automatic test_dir();
        logic [3:0] f;
        @(posedge clk);
        rd_log <= 8'h05;
        rd_start <= 1'b1;
        @(posedge clk);
        rd_start <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({15'h0000, rd_busy}, 16'h0000, "unknown log");
        for (int p = 0; p < 2; p++) begin
            f = (p == 1) ? 4'hA : 4'h5;
            @(posedge clk);
            {reb, qm, phy, ncq} <= f;
            stall <= (p == 1);
            read_log(LOG_DIR, p == 0);
            chk_b(0, 8'h01, "version low");
            chk_b(1, 8'h00, "version high");
            chk({15'h0000, dir_present}, 16'h0001, "directory present");
            chk_b(6, 8'h01, "error log size");
            chk_b(7, 8'h00, "error log size high");
            chk_b(14, 8'h01, "self-test log size");
            for (int a = 128; a < 160; a++) chk_b(2 * a, 8'h10, "vendor size");
            for (int a = 128; a < 160; a++) chk_b(2 * a + 1, 8'h00, "vendor size high");
            chk_b(9'h020, {7'h00, f[0]}, "queuing");
            chk_b(9'h021, 8'h00, "queuing high");
            chk_b(9'h022, {7'h00, f[1]}, "phy counters");
            chk_b(9'h023, 8'h00, "phy counters high");
            chk_b(9'h024, {7'h00, f[2]}, "queue management");
            chk_b(9'h025, 8'h00, "queue management high");
            chk_b(9'h02A, {7'h00, f[3]}, "rebuild assist");
            chk_b(9'h02B, 8'h00, "rebuild assist high");
            chk_zero(9'h026, 9'h029);
        end
    endtask : test_dir

    task automatic test_err_empty();
        errs(8'h60, 1, 0, 1'b1);
        read_log(LOG_ERR, 1'b0);
        chk_b(0, 8'h01, "error version");
        chk_b(2, 8'h00, "empty index");
        chk_zero(4, 9'h1F3);
        chk_b(9'h1F4, 8'h00, "empty count");
        chk_sum();
    endtask : test_err_empty

    task automatic test_err_ring();
        errs(8'h01, 5, 1, 1'b0);
        stall <= 1'b1;
        read_log(LOG_ERR, 1'b0);
        chk_b(2, 8'h01, "wrapped index");
        chk_b(3, 8'h00, "index high");
        chk_b(9'h1F4, 8'h05, "count");
        chk_b(9'h1F5, 8'h00, "count high");
        for (int k = 0; k < 4; k++) chk_entry(4 + 124 * k, (k == 0) ? 8'h05 : 8'(k + 1));
        chk_sum();
    endtask : test_err_ring

    task automatic test_state_codes();
        int idx;
        for (int s = 0; s < 16; s++) begin
            errs(8'h10 + 8'(s), 1, 0, 1'b0);
            read_log(LOG_ERR, 1'b0);
            idx = ((5 + s) % 4) + 1;
            chk_b(2, 8'(idx), "index step");
            chk_entry(4 + 124 * (idx - 1), 8'h10 + 8'(s));
        end
    endtask : test_state_codes

    task automatic test_err_saturate();
        errs(8'h09, 65540, 0, 1'b0);
        read_log(LOG_ERR, 1'b0);
        chk_b(9'h1F4, 8'hFF, "saturated count");
        chk_b(9'h1F5, 8'hFF, "saturated count high");
        chk_b(2, 8'h01, "index after bulk");
        chk_entry(4, 8'h09);
        chk_sum();
    endtask : test_err_saturate

    task automatic test_selftest();
        int b;
        read_log(LOG_ST, 1'b0);
        chk_b(0, 8'h01, "revision");
        chk_b(2, 8'h00, "empty index");
        chk_zero(4, 9'h1F1);
        chk_sum();
        for (int i = 1; i <= 19; i++) begin
            @(posedge clk);
            st_valid <= 1'b1;
            st_desc <= '{fail_lba: {40'h0, 8'(i)}, check_point: 8'hC0, hours: {8'h33, 8'(i)}, status: 8'h20,
                number: 8'(i)};
        end
        @(posedge clk);
        st_valid <= 1'b0;
        read_log(LOG_ST, 1'b0);
        chk_b(2, 8'h01, "wrapped index");
        for (int k = 1; k <= 17; k++) begin
            b = 4 + 26 * (k - 1);
            chk_b(b, (k == 1) ? 8'h13 : 8'(k), "test number");
            chk_b(b + 2, (k == 1) ? 8'h13 : 8'(k), "hours low");
            chk_b(b + 4, 8'hC0, "check point");
        end
        chk_sum();
    endtask : test_selftest

    initial begin
        {rst_n, ncq, phy, qm, reb, err_valid, err_faulty_cmd, st_valid, rd_start, clr, stall} = '0;
        rd_log = 8'h00;
        err_entry = '0;
        st_desc = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        test_dir();
        test_err_empty();
        test_err_ring();
        test_state_codes();
        test_err_saturate();
        test_selftest();
        summarize();
    end
endmodule : tb
